// >>> design/lp2_p3_if.sv
// carrier between the register core and the port 3 input router
`timescale 1ns/10ps
interface lp2_p3_if;
    // mode bits from the register core
    logic analog_en;
    logic ir_amp_en;
    // raw pin levels
    logic [3:0] pin_in;
    // routed results
    logic [3:0] dig_in;
    logic [3:0] cmp_sel;
    logic amp_sel;
    modport ctl (
        output analog_en,
        output ir_amp_en,
        output pin_in,
        input dig_in,
        input cmp_sel,
        input amp_sel
    );
    modport route (
        input analog_en,
        input ir_amp_en,
        input pin_in,
        output dig_in,
        output cmp_sel,
        output amp_sel
    );
endinterface : lp2_p3_if

// >>> design/lp2_p3_route.sv
// port 3 low-nibble input routing: digital, comparator or ir amplifier
`timescale 1ns/10ps
module lp2_p3_route (
    lp2_p3_if.route p3
);
    // pin one goes to the amplifier whenever it is enabled
    wire amp_on = p3.ir_amp_en;
    // pin one is a comparator input only in analog mode without amplifier
    wire pin1_cmp = p3.analog_en & ~p3.ir_amp_en;
    // pin one is digital only when neither analog function claims it
    wire pin1_dig = ~p3.analog_en & ~p3.ir_amp_en;
    // analog mode takes pins zero, two and three to the comparators
    wire others_cmp = p3.analog_en;

    assign p3.amp_sel = amp_on;
    // comparator routing per pin
    assign p3.cmp_sel[lp2_pkg::PIN_ZERO] = others_cmp;
    assign p3.cmp_sel[lp2_pkg::PIN_ONE] = pin1_cmp;
    assign p3.cmp_sel[lp2_pkg::PIN_TWO] = others_cmp;
    assign p3.cmp_sel[lp2_pkg::PIN_THREE] = others_cmp;
    // digital inputs pass unless the pin is claimed: pins zero, two and three by analog mode, pin one also by the amplifier
    assign p3.dig_in[lp2_pkg::PIN_ZERO] = p3.pin_in[lp2_pkg::PIN_ZERO] & ~others_cmp;
    assign p3.dig_in[lp2_pkg::PIN_ONE] = p3.pin_in[lp2_pkg::PIN_ONE] & pin1_dig;
    assign p3.dig_in[lp2_pkg::PIN_TWO] = p3.pin_in[lp2_pkg::PIN_TWO] & ~others_cmp;
    assign p3.dig_in[lp2_pkg::PIN_THREE] = p3.pin_in[lp2_pkg::PIN_THREE] & ~others_cmp;
endmodule : lp2_p3_route

// >>> design/lp2_pkg.sv
// constants for the port 2 i/o and port 3 input mode block
package lp2_pkg;
    // register bus shape
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int P2_W = 8;
    localparam int P3_W = 4;
    // register offsets
    localparam logic [7:0] OFF_PORT2_DATA = 8'h02;
    localparam logic [7:0] OFF_PORT2_DIR = 8'hf6;
    localparam logic [7:0] OFF_INPUT_MODE = 8'hf7;
    // reset values
    localparam logic [7:0] DIR_RESET = 8'hff;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic MODE_BIT_RESET = 1'b0;
    // input mode register fields
    localparam int MODE_PUSH_PULL_BIT = 0;
    localparam int MODE_ANALOG_BIT = 1;
    localparam int MODE_IR_AMP_BIT = 2;
    // write-only bits and reserved bits all read as ones
    localparam logic [7:0] MODE_READ_VALUE = 8'hff;
    // answer to an unmapped read
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // port 3 pin positions
    localparam int PIN_ZERO = 0;
    localparam int PIN_ONE = 1;
    localparam int PIN_TWO = 2;
    localparam int PIN_THREE = 3;
    // all pins released
    localparam logic [7:0] ALL_RELEASED = 8'hff;
    localparam logic [7:0] NONE_SET = 8'h00;
endpackage : lp2_pkg

// >>> design/lp2_port_io.sv
// port 2 bidirectional i/o with port 3 input mode selection
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
module lp2_port_io #(
    parameter int P2_W = lp2_pkg::P2_W
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic stop_mode_recovery,
    // register port
    input wire logic [lp2_pkg::ADDR_W-1:0] addr,
    input wire logic [lp2_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [lp2_pkg::DATA_W-1:0] rdata,
    // port 2 pins
    input wire logic [P2_W-1:0] port2_in,
    output logic [P2_W-1:0] port2_out,
    output logic [P2_W-1:0] port2_oe_n,
    // port 3 low nibble
    input wire logic [lp2_pkg::P3_W-1:0] port3_in,
    output logic [lp2_pkg::P3_W-1:0] port3_dig_in,
    output logic [lp2_pkg::P3_W-1:0] port3_cmp_sel,
    output logic ir_amp_sel,
    output logic first_comparator_en
);
    // address match helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // state
    logic [P2_W-1:0] port2_direction_reg_r;
    logic [P2_W-1:0] port2_direction_reg_nxt;
    logic [P2_W-1:0] port2_data_reg_r;
    logic [P2_W-1:0] port2_data_reg_nxt;
    logic push_pull_r;
    logic push_pull_nxt;
    logic analog_r;
    logic analog_nxt;
    logic ir_amp_r;
    logic ir_amp_nxt;
    logic [lp2_pkg::DATA_W-1:0] rdata_r;
    logic [lp2_pkg::DATA_W-1:0] rdata_nxt;

    // address decode
    wire sel_data = hit(addr, lp2_pkg::OFF_PORT2_DATA);
    wire sel_dir = hit(addr, lp2_pkg::OFF_PORT2_DIR);
    wire sel_mode = hit(addr, lp2_pkg::OFF_INPUT_MODE);
    wire wr_data = ce & wr & sel_data;
    wire wr_dir = ce & wr & sel_dir;
    wire wr_mode = ce & wr & sel_mode;

    // next values; stop-mode recovery has no path into these
    assign port2_direction_reg_nxt = wr_dir ? wdata[P2_W-1:0] : port2_direction_reg_r;
    assign port2_data_reg_nxt = wr_data ? wdata[P2_W-1:0] : port2_data_reg_r;
    // only the three control bits are taken; upper bits dropped
    assign push_pull_nxt = wr_mode ? wdata[lp2_pkg::MODE_PUSH_PULL_BIT] : push_pull_r;
    assign analog_nxt = wr_mode ? wdata[lp2_pkg::MODE_ANALOG_BIT] : analog_r;
    assign ir_amp_nxt = wr_mode ? wdata[lp2_pkg::MODE_IR_AMP_BIT] : ir_amp_r;

    // read mux: pins live, direction readable, mode reads all ones
    assign rdata_nxt = (rd & sel_data) ? port2_in :
                       (rd & sel_dir) ? port2_direction_reg_r :
                       (rd & sel_mode) ? lp2_pkg::MODE_READ_VALUE :
                       lp2_pkg::UNMAPPED_READ;

    // register core; only resetn returns values to defaults
    always_ff @(posedge clk) begin
        if (!resetn) begin
            port2_direction_reg_r <= lp2_pkg::DIR_RESET;
            port2_data_reg_r <= lp2_pkg::DATA_RESET;
            push_pull_r <= lp2_pkg::MODE_BIT_RESET;
            analog_r <= lp2_pkg::MODE_BIT_RESET;
            ir_amp_r <= lp2_pkg::MODE_BIT_RESET;
            rdata_r <= lp2_pkg::UNMAPPED_READ;
        end else if (ce) begin
            port2_direction_reg_r <= port2_direction_reg_nxt;
            port2_data_reg_r <= port2_data_reg_nxt;
            push_pull_r <= push_pull_nxt;
            analog_r <= analog_nxt;
            ir_amp_r <= ir_amp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

    // pin drivers: enable low drives; input pins never driven
    wire [P2_W-1:0] float_high = push_pull_r ? {P2_W{1'b0}} : port2_data_reg_r;
    assign port2_out = port2_data_reg_r;
    assign port2_oe_n = port2_direction_reg_r | float_high;

    // port 3 routing
    lp2_p3_if p3 ();
    assign p3.analog_en = analog_r;
    assign p3.ir_amp_en = ir_amp_r;
    assign p3.pin_in = port3_in;

    lp2_p3_route u_route (
        .p3(p3.route)
    );

    assign port3_dig_in = p3.dig_in;
    assign port3_cmp_sel = p3.cmp_sel;
    assign ir_amp_sel = p3.amp_sel;
    // first comparator runs only while the amplifier does not replace it
    assign first_comparator_en = analog_r & ~ir_amp_r;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_dir_write;
        ce && wr && sel_dir |=> port2_direction_reg_r == $past(wdata);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not stored");

    property p_reset_inputs;
        $past(!resetn) |-> port2_oe_n == lp2_pkg::ALL_RELEASED;
    endproperty
    a_reset_inputs: assert property (p_reset_inputs)
        else $error("pins driven right after reset");

    property p_smr_keep;
        ce && stop_mode_recovery && !wr |=>
            $stable(port2_direction_reg_r) && $stable(push_pull_r) && $stable(analog_r) && $stable(ir_amp_r);
    endproperty
    a_smr_keep: assert property (p_smr_keep)
        else $error("stop-mode recovery changed a mode register");

    property p_read_pins;
        ce && rd && sel_data |=> rdata == $past(port2_in);
    endproperty
    a_read_pins: assert property (p_read_pins)
        else $error("data read is not the pin level");

    property p_inputs_free;
        (~port2_oe_n & port2_direction_reg_r) == lp2_pkg::NONE_SET;
    endproperty
    a_inputs_free: assert property (p_inputs_free)
        else $error("input pin driven");

    property p_drive_low;
        ce && wr && sel_data && wdata == lp2_pkg::NONE_SET && port2_direction_reg_r == lp2_pkg::NONE_SET
            && !(wr_dir) |=> port2_oe_n == lp2_pkg::NONE_SET && port2_out == lp2_pkg::NONE_SET;
    endproperty
    a_drive_low: assert property (p_drive_low)
        else $error("zero write did not drive pins low");

    property p_open_drain;
        !push_pull_r |-> (~port2_oe_n & port2_out) == lp2_pkg::NONE_SET;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin driven high");

    property p_mode_reset;
        $past(!resetn) |-> !push_pull_r && !analog_r && !ir_amp_r;
    endproperty
    a_mode_reset: assert property (p_mode_reset)
        else $error("mode bits not cleared by reset");

    property p_digital;
        !analog_r && !ir_amp_r |-> port3_dig_in == port3_in && port3_cmp_sel == 4'h0;
    endproperty
    a_digital: assert property (p_digital)
        else $error("digital mode not passing inputs");

    property p_analog;
        ce && wr && sel_mode && wdata[lp2_pkg::MODE_ANALOG_BIT] |=>
            port3_cmp_sel[lp2_pkg::PIN_ZERO] && port3_cmp_sel[lp2_pkg::PIN_TWO]
            && port3_cmp_sel[lp2_pkg::PIN_THREE] && !port3_dig_in[lp2_pkg::PIN_ZERO];
    endproperty
    a_analog: assert property (p_analog)
        else $error("analog mode not routing comparators");

    property p_amp;
        ce && wr && sel_mode && wdata[lp2_pkg::MODE_IR_AMP_BIT] |=>
            ir_amp_sel && !first_comparator_en && !port3_cmp_sel[lp2_pkg::PIN_ONE];
    endproperty
    a_amp: assert property (p_amp)
        else $error("amplifier not replacing first comparator");

    property p_pin_one;
        port3_cmp_sel[lp2_pkg::PIN_ONE] == (analog_r && !ir_amp_r) && ir_amp_sel == ir_amp_r;
    endproperty
    a_pin_one: assert property (p_pin_one)
        else $error("pin one routed wrongly");

    property p_mode_read;
        ce && rd && sel_mode |=> rdata == lp2_pkg::MODE_READ_VALUE;
    endproperty
    a_mode_read: assert property (p_mode_read)
        else $error("mode register read not all ones");

    // a low enable freezes every register, read data included
    property p_ce_freeze;
        !ce |=> $stable(port2_direction_reg_r) && $stable(port2_data_reg_r) && $stable(push_pull_r)
            && $stable(analog_r) && $stable(ir_amp_r) && $stable(rdata_r);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("register changed while enable low");

    // read data returns to the idle value after any enabled cycle without a read
    property p_rdata_idle;
        ce && !rd |=> rdata == lp2_pkg::UNMAPPED_READ;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not idle without a read");

    // a read outside the three offsets answers the idle value
    property p_unmapped_read;
        ce && rd && !sel_data && !sel_dir && !sel_mode |=> rdata == lp2_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not answered with idle value");

    // direction register reads back what is stored
    property p_dir_read;
        ce && rd && sel_dir |=> rdata == $past(port2_direction_reg_r);
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction read does not match register");

    // a data write lands in the output latch
    property p_data_write;
        ce && wr && sel_data |=> port2_out == $past(wdata);
    endproperty
    a_data_write: assert property (p_data_write)
        else $error("data write not held in output latch");

    // push-pull drives every output pin whatever the latch holds
    property p_push_pull_drive;
        push_pull_r |-> port2_oe_n == port2_direction_reg_r;
    endproperty
    a_push_pull_drive: assert property (p_push_pull_drive)
        else $error("push-pull output pin not driven");

    // the three control bits take the written value
    property p_mode_write;
        ce && wr && sel_mode |=> push_pull_r == $past(wdata[lp2_pkg::MODE_PUSH_PULL_BIT])
            && analog_r == $past(wdata[lp2_pkg::MODE_ANALOG_BIT]) && ir_amp_r == $past(wdata[lp2_pkg::MODE_IR_AMP_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write not stored");

    // direction changes only by its own write
    property p_dir_keep;
        ce && !wr_dir |=> $stable(port2_direction_reg_r);
    endproperty
    a_dir_keep: assert property (p_dir_keep)
        else $error("direction changed without a write");

    // data latch changes only by its own write
    property p_data_keep;
        ce && !wr_data |=> $stable(port2_data_reg_r);
    endproperty
    a_data_keep: assert property (p_data_keep)
        else $error("data latch changed without a write");

    // amplifier claims pin one whatever the analog bit says
    property p_amp_indep;
        ir_amp_r |-> ir_amp_sel && !first_comparator_en && !port3_dig_in[lp2_pkg::PIN_ONE];
    endproperty
    a_amp_indep: assert property (p_amp_indep)
        else $error("amplifier mode not claiming pin one");

    // analog mode holds pins zero, two and three away from the digital path
    property p_analog_claim;
        analog_r |-> port3_cmp_sel[lp2_pkg::PIN_ZERO] && port3_cmp_sel[lp2_pkg::PIN_TWO]
            && port3_cmp_sel[lp2_pkg::PIN_THREE] && !port3_dig_in[lp2_pkg::PIN_TWO] && !port3_dig_in[lp2_pkg::PIN_THREE];
    endproperty
    a_analog_claim: assert property (p_analog_claim)
        else $error("analog mode left a pin digital");

    // analog mode without amplifier makes pin one a comparator input
    property p_analog_pin_one;
        analog_r && !ir_amp_r |-> port3_cmp_sel[lp2_pkg::PIN_ONE] && !port3_dig_in[lp2_pkg::PIN_ONE] && first_comparator_en;
    endproperty
    a_analog_pin_one: assert property (p_analog_pin_one)
        else $error("pin one not a comparator input");

    // main scenarios
    c_push_pull_drive: cover property (push_pull_r && port2_oe_n != lp2_pkg::ALL_RELEASED);
    c_open_drain_float: cover property (!push_pull_r && (~port2_direction_reg_r & port2_data_reg_r) != lp2_pkg::NONE_SET);
    c_amp_analog: cover property (analog_r && ir_amp_r);
    c_smr_seen: cover property (ce && stop_mode_recovery ##1 ce && rd && sel_dir);
endmodule : lp2_port_io

// >>> test/lp2_pin_model.sv
// far-side pin model: resolves port 2 pin levels from device drivers and an external load
`timescale 1ns/10ps
module lp2_pin_model (
    // device side
    input wire logic [7:0] out,
    input wire logic [7:0] oe_n,
    // external side
    input wire logic [7:0] ext,
    output logic [7:0] level
);
    // a released pin follows the external source, a driven pin the device latch
    assign level = (oe_n & ext) | (~oe_n & out);
endmodule : lp2_pin_model

// >>> test/lp2_port_io_tb.sv
// self-checking bench for the port 2 i/o and port 3 input mode block
`timescale 1ns/10ps
module lp2_port_io_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic stop_mode_recovery = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [7:0] port2_out;
    logic [7:0] port2_oe_n;
    logic [7:0] pin_level;
    logic [7:0] ext = 8'h00;
    logic [3:0] port3_in = 4'h0;
    logic [3:0] port3_dig_in;
    logic [3:0] port3_cmp_sel;
    logic ir_amp_sel;
    logic first_comparator_en;
    int seed;
    int bad_count = 0;
    int samples_checked = 0;
    logic [7:0] dir;
    logic [7:0] dat;
    logic [7:0] exp_oe;
    logic [7:0] got;
    logic [2:0] m;

    // device under test and its pins
    lp2_port_io i_dut (.clk(clk), .resetn(resetn), .ce(ce), .stop_mode_recovery(stop_mode_recovery),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port2_in(pin_level),
        .port2_out(port2_out), .port2_oe_n(port2_oe_n), .port3_in(port3_in), .port3_dig_in(port3_dig_in),
        .port3_cmp_sel(port3_cmp_sel), .ir_amp_sel(ir_amp_sel), .first_comparator_en(first_comparator_en));
    lp2_pin_model i_pins (.out(port2_out), .oe_n(port2_oe_n), .ext(ext), .level(pin_level));

    // 50 ns clock
    always #25 clk = ~clk;

    // expected routing: {digital, comparator select, amplifier, first comparator}
    function automatic logic [9:0] p3_exp(input logic [2:0] md, input logic [3:0] pin);
        logic [3:0] claim;
        claim = {md[1], md[1], md[1] | md[2], md[1]};
        return {pin & ~claim, md[1], md[1], md[1] & ~md[2], md[1], md[2], md[1] & ~md[2]};
    endfunction : p3_exp

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic chk_p3(input logic [2:0] md);
        logic [9:0] g;
        g = {port3_dig_in, port3_cmp_sel, ir_amp_sel, first_comparator_en};
        samples_checked++;
        if (g !== p3_exp(md, port3_in)) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, p3_exp(md, port3_in));
        end
    endtask : chk_p3

    // register port master
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    task automatic test_done;
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    // watchdog
    initial begin
        #(50 * 20000);
        bad_count++;
        test_done();
    end

    // main sequence
    initial begin
        seed = 56193;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk(port2_oe_n, 8'hff);
        chk(port2_out, 8'h00);
        chk_p3(3'h0);
        rd_reg(8'hf6, got);
        chk(got, 8'hff);
        rd_reg(8'hf7, got);
        chk(got, 8'hff);
        $display("test reset done");
        for (int i = 0; i < 24; i++) begin
            dir = (i == 1) ? 8'h00 : 8'($random(seed));
            dat = (i == 1) ? 8'h00 : 8'($random(seed));
            m = (i < 8) ? i[2:0] : 3'($random(seed));
            @(posedge clk);
            ext <= 8'($random(seed));
            port3_in <= 4'($random(seed));
            wr_reg(8'hf6, dir);
            wr_reg(8'h02, dat);
            wr_reg(8'hf7, {5'($random(seed)), m});
            @(negedge clk);
            exp_oe = dir | (m[0] ? 8'h00 : dat);
            chk(port2_oe_n, exp_oe);
            chk(port2_out & ~port2_oe_n, dat & ~exp_oe);
            chk_p3(m);
            rd_reg(8'h02, got);
            chk(got, (exp_oe & ext) | (~exp_oe & dat));
            rd_reg(8'hf6, got);
            chk(got, dir);
            rd_reg(8'hf7, got);
            chk(got, 8'hff);
        end
        $display("test random done");
        @(posedge clk);
        stop_mode_recovery <= 1'b1;
        rd_reg(8'hf6, got);
        chk(got, dir);
        @(posedge clk);
        stop_mode_recovery <= 1'b0;
        @(negedge clk);
        chk(port2_oe_n, exp_oe);
        chk_p3(m);
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(8'hf6, ~dir);
        ce <= 1'b1;
        rd_reg(8'hf6, got);
        chk(got, dir);
        rd_reg(8'h55, got);
        chk(got, 8'h00);
        $display("test recovery done");
        test_done();
    end
endmodule : lp2_port_io_tb
